// ### rtl/ims_interrupt_unit.sv
module ims_interrupt_unit (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic app_mode,
  input wire logic [ims_pkg::ADDR_W-1:0] cpu_addr,
  input wire logic [ims_pkg::DATA_W-1:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [ims_pkg::DATA_W-1:0] cpu_rdata,
  input wire logic [ims_pkg::ADDR_W-1:0] dbg_addr,
  input wire logic [ims_pkg::DATA_W-1:0] dbg_wdata,
  input wire logic dbg_wr,
  input wire logic dbg_rd,
  output logic [ims_pkg::DATA_W-1:0] dbg_rdata,
  input wire logic [ims_pkg::DATA_W-1:0] src_event,
  input wire logic [ims_pkg::DATA_W-1:0] src_clear,
  output logic irq,
  output logic [ims_pkg::DATA_W-1:0] pending,
  output logic [ims_pkg::DATA_W-1:0] missed,
  output logic software_source,
  output logic prot_reject
);

  typedef struct packed {
    logic [ims_pkg::DATA_W-1:0] flag;
    logic [ims_pkg::DATA_W-1:0] miss;
    logic [ims_pkg::DATA_W-1:0] cfg;
    logic [ims_pkg::DATA_W-1:0] gen;
    logic [ims_pkg::DATA_W-1:0] swtrig;
    logic sw_pulse;
    logic reject;
    logic irq;
  } ims_state_t;

  ims_state_t st_reg;
  ims_state_t st_next;

  ims_pkg::ims_sel_t cpu_sel;
  ims_pkg::ims_sel_t dbg_sel;
  logic [ims_pkg::DATA_W-1:0] cpu_allow;
  logic [ims_pkg::DATA_W-1:0] events;
  logic [ims_pkg::DATA_W-1:0] flag_clr;
  logic [ims_pkg::DATA_W-1:0] miss_clr;
  logic [ims_pkg::DATA_W-1:0] flag_set;
  logic [ims_pkg::DATA_W-1:0] miss_set;
  logic [ims_pkg::DATA_W-1:0] cfg_tmp;
  logic [ims_pkg::DATA_W-1:0] gen_tmp;
  logic sw_fire;

  assign cpu_sel = cpu_wr ? ims_pkg::ims_decode(cpu_addr) : ims_pkg::SEL_NONE;
  // debug accesses come from outside the core and carry no application privilege
  assign dbg_sel = dbg_wr ? ims_pkg::ims_decode(dbg_addr) : ims_pkg::SEL_NONE;
  assign cpu_allow = ims_pkg::ims_allow(ims_pkg::SRC_MASK, app_mode);

  always_comb
  begin
    st_next = st_reg;
    flag_clr = '0;
    miss_clr = '0;
    cfg_tmp = st_reg.cfg;
    gen_tmp = st_reg.gen;
    sw_fire = 1'b0;
    st_next.reject = 1'b0;

    // processor port, privilege checked per bit on flag, clear, miss and config writes only
    unique case (cpu_sel)
      ims_pkg::SEL_FLAG,
      ims_pkg::SEL_CLR:
      begin
        flag_clr = flag_clr | (cpu_wdata & cpu_allow & ims_pkg::FLAG_WR_MASK);
      end
      ims_pkg::SEL_MISS:
      begin
        miss_clr = miss_clr | (cpu_wdata & cpu_allow);
      end
      ims_pkg::SEL_CFG:
      begin
        cfg_tmp = (cfg_tmp & ~cpu_allow) | (cpu_wdata & cpu_allow);
      end
      ims_pkg::SEL_GEN:
      begin
        gen_tmp = cpu_wdata & ims_pkg::GEN_MASK;
      end
      ims_pkg::SEL_SWTRIG:
      begin
        st_next.swtrig = cpu_wdata;
        sw_fire = 1'b1;
      end
      ims_pkg::SEL_NONE:
      begin
        sw_fire = sw_fire;
      end
    endcase

    if (cpu_wr && app_mode && (cpu_sel inside {ims_pkg::SEL_FLAG, ims_pkg::SEL_CLR,
        ims_pkg::SEL_MISS, ims_pkg::SEL_CFG}))
    begin
      st_next.reject = |(cpu_wdata & ims_pkg::PROT_MASK);
    end

    // debug port lands after the processor, so its config, gen and trigger writes win a same-cycle clash; flag and miss clears from both ports combine
    unique case (dbg_sel)
      ims_pkg::SEL_FLAG,
      ims_pkg::SEL_CLR:
      begin
        flag_clr = flag_clr | (dbg_wdata & ims_pkg::FLAG_WR_MASK);
      end
      ims_pkg::SEL_MISS:
      begin
        miss_clr = miss_clr | (dbg_wdata & ims_pkg::SRC_MASK);
      end
      ims_pkg::SEL_CFG:
      begin
        cfg_tmp = dbg_wdata & ims_pkg::SRC_MASK;
      end
      ims_pkg::SEL_GEN:
      begin
        gen_tmp = dbg_wdata & ims_pkg::GEN_MASK;
      end
      ims_pkg::SEL_SWTRIG:
      begin
        st_next.swtrig = dbg_wdata;
        sw_fire = 1'b1;
      end
      ims_pkg::SEL_NONE:
      begin
        sw_fire = sw_fire;
      end
    endcase

    // peripherals drop their read-only pending bits themselves
    flag_clr = flag_clr | (src_clear & ~ims_pkg::FLAG_WR_MASK);

    events = (src_event | ({{(ims_pkg::DATA_W-1){1'b0}}, sw_fire} << ims_pkg::BIT_SW))
             & ims_pkg::SRC_MASK;
    flag_set = events;
    // an event on a source still pending is counted as missed
    miss_set = events & st_reg.flag;

    // set wins over clear so no event is lost in the clearing cycle
    st_next.flag = ((st_reg.flag & ~flag_clr) | flag_set) & ims_pkg::SRC_MASK;
    st_next.miss = ((st_reg.miss & ~miss_clr) | miss_set) & ims_pkg::SRC_MASK;
    st_next.cfg = cfg_tmp & ims_pkg::SRC_MASK;
    st_next.gen = gen_tmp & ims_pkg::GEN_MASK;
    st_next.sw_pulse = sw_fire;
    st_next.irq = st_next.gen[ims_pkg::BIT_GEN] & (|(st_next.flag & st_next.cfg));
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg.flag <= ims_pkg::RST_FLAG;
      st_reg.miss <= ims_pkg::RST_MISS;
      st_reg.cfg <= ims_pkg::RST_CFG;
      st_reg.gen <= ims_pkg::RST_GEN;
      st_reg.swtrig <= ims_pkg::RST_SWTRIG;
      st_reg.sw_pulse <= 1'b0;
      st_reg.reject <= 1'b0;
      st_reg.irq <= 1'b0;
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  // two read ports, so a debug read never steals a processor cycle
  ims_rd_port u_cpu_rd (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .rd_stb(cpu_rd),
    .addr(cpu_addr),
    .flag_val(st_reg.flag),
    .miss_val(st_reg.miss),
    .gen_val(st_reg.gen),
    .cfg_val(st_reg.cfg),
    .swtrig_val(st_reg.swtrig),
    .rdata(cpu_rdata)
  );

  ims_rd_port u_dbg_rd (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .rd_stb(dbg_rd),
    .addr(dbg_addr),
    .flag_val(st_reg.flag),
    .miss_val(st_reg.miss),
    .gen_val(st_reg.gen),
    .cfg_val(st_reg.cfg),
    .swtrig_val(st_reg.swtrig),
    .rdata(dbg_rdata)
  );

  assign irq = st_reg.irq;
  assign pending = st_reg.flag;
  assign missed = st_reg.miss;
  assign software_source = st_reg.sw_pulse;
  assign prot_reject = st_reg.reject;

endmodule

// ### rtl/ims_pkg.sv
// Operation
// - radio receive miss flag at bit 10; writes from application mode are dropped.
// - baseband miss flag at bit 3; writes from application mode are dropped.
// - debug port miss flag at bit 2; writes from application mode are dropped.
// - any write to the software trigger register raises the software source.
// - debug port reads registers without disturbing the processor port; its config, gen and trigger writes override a same-cycle processor write.
// - debug port enable bit at bit 2; writes from application mode are dropped.
// - debug port pending flag at bit 2; writes from application mode are dropped.
package ims_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 16;

  // register addresses
  localparam logic [ADDR_W-1:0] OFS_FLAG = 16'h4600;
  localparam logic [ADDR_W-1:0] OFS_MISS = 16'h4602;
  localparam logic [ADDR_W-1:0] OFS_CLR = 16'h4604;
  localparam logic [ADDR_W-1:0] OFS_GEN = 16'h4618;
  localparam logic [ADDR_W-1:0] OFS_CFG = 16'h461a;
  localparam logic [ADDR_W-1:0] OFS_SWTRIG = 16'h4638;

  // source bit positions, and the enable bit in the gen register
  localparam int unsigned BIT_SW = 1;
  localparam int unsigned BIT_DBG = 2;
  localparam int unsigned BIT_BB = 3;
  localparam int unsigned BIT_RX = 10;
  localparam int unsigned BIT_GEN = 0;

  // field masks
  localparam logic [DATA_W-1:0] SRC_MASK = 16'hfffe;
  localparam logic [DATA_W-1:0] PROT_MASK = 16'hc79e;
  localparam logic [DATA_W-1:0] FLAG_WR_MASK = 16'hc806;
  localparam logic [DATA_W-1:0] GEN_MASK = 16'h0001;

  // reset values
  localparam logic [DATA_W-1:0] RST_FLAG = 16'h0000;
  localparam logic [DATA_W-1:0] RST_MISS = 16'h0000;
  localparam logic [DATA_W-1:0] RST_CFG = 16'h0000;
  localparam logic [DATA_W-1:0] RST_GEN = 16'h0000;
  localparam logic [DATA_W-1:0] RST_SWTRIG = 16'h0000;
  localparam logic [DATA_W-1:0] RST_RDATA = 16'h0000;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_FLAG,
    SEL_MISS,
    SEL_CLR,
    SEL_GEN,
    SEL_CFG,
    SEL_SWTRIG
  } ims_sel_t;

  function automatic ims_sel_t ims_decode(input logic [ADDR_W-1:0] addr);
    ims_sel_t sel;
    sel = SEL_NONE;
    case (addr)
      OFS_FLAG: sel = SEL_FLAG;
      OFS_MISS: sel = SEL_MISS;
      OFS_CLR: sel = SEL_CLR;
      OFS_GEN: sel = SEL_GEN;
      OFS_CFG: sel = SEL_CFG;
      OFS_SWTRIG: sel = SEL_SWTRIG;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction

  // bits a writer may touch, given the writable field and the privilege of the access
  function automatic logic [DATA_W-1:0] ims_allow(
    input logic [DATA_W-1:0] writable,
    input logic app
  );
    return app ? (writable & ~PROT_MASK) : writable;
  endfunction

endpackage

// ### rtl/ims_rd_port.sv
module ims_rd_port (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic rd_stb,
  input wire logic [ims_pkg::ADDR_W-1:0] addr,
  input wire logic [ims_pkg::DATA_W-1:0] flag_val,
  input wire logic [ims_pkg::DATA_W-1:0] miss_val,
  input wire logic [ims_pkg::DATA_W-1:0] gen_val,
  input wire logic [ims_pkg::DATA_W-1:0] cfg_val,
  input wire logic [ims_pkg::DATA_W-1:0] swtrig_val,
  output logic [ims_pkg::DATA_W-1:0] rdata
);

  typedef struct packed {
    logic [ims_pkg::DATA_W-1:0] rdata;
  } ims_rd_state_t;

  ims_rd_state_t st_reg;
  ims_rd_state_t st_next;

  // data stands only in the cycle after the strobe, zero otherwise
  always_comb
  begin
    st_next = st_reg;
    st_next.rdata = ims_pkg::RST_RDATA;
    if (rd_stb)
    begin
      unique case (ims_pkg::ims_decode(addr))
        ims_pkg::SEL_FLAG: st_next.rdata = flag_val;
        ims_pkg::SEL_MISS: st_next.rdata = miss_val;
        ims_pkg::SEL_GEN: st_next.rdata = gen_val;
        ims_pkg::SEL_CFG: st_next.rdata = cfg_val;
        ims_pkg::SEL_SWTRIG: st_next.rdata = swtrig_val;
        ims_pkg::SEL_CLR: st_next.rdata = ims_pkg::RST_RDATA;
        ims_pkg::SEL_NONE: st_next.rdata = ims_pkg::RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;

endmodule

// ### verif/ims_interrupt_unit_properties.sv
module ims_interrupt_unit_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic app_mode,
  input wire logic [15:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic [15:0] dbg_addr,
  input wire logic [15:0] dbg_wdata,
  input wire logic dbg_wr,
  input wire logic dbg_rd,
  input wire logic [15:0] dbg_rdata,
  input wire logic [15:0] src_event,
  input wire logic [15:0] pending,
  input wire logic [15:0] missed,
  input wire logic software_source,
  input wire logic prot_reject
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_trig_wr;
    ce && cpu_wr && cpu_addr == ims_pkg::OFS_SWTRIG;
  endsequence
  // debug write left out so a same-cycle privileged write cannot mask the check
  sequence s_app_wr;
    ce && cpu_wr && app_mode && !dbg_wr && src_event == 16'h0000;
  endsequence
  a_trig_pulse: assert property (s_trig_wr |=> software_source && pending[1])
    else $error("trigger write gave no software source");
  a_miss_rx: assert property (ce && src_event[10] && pending[10] |=> missed[10])
    else $error("receive miss not set");
  a_app_miss_keep: assert property (s_app_wr ##0 cpu_addr == ims_pkg::OFS_MISS
    |=> (missed & 16'h040c) == ($past(missed) & 16'h040c))
    else $error("application write changed a protected miss bit");
  a_dbg_miss_clr: assert property (ce && dbg_wr && dbg_addr == ims_pkg::OFS_MISS
    && dbg_wdata[2] && !src_event[2] |=> !missed[2])
    else $error("debug write did not clear miss bit");
  a_app_flag_keep: assert property (s_app_wr ##0 cpu_addr == ims_pkg::OFS_FLAG
    && pending[2] |=> pending[2])
    else $error("application write cleared debug pending");
  a_dbg_read_miss: assert property (ce && dbg_rd && dbg_addr == ims_pkg::OFS_MISS
    |=> dbg_rdata == $past(missed))
    else $error("debug read of miss wrong");
  a_cfg_reject: assert property (s_app_wr ##0 cpu_addr == ims_pkg::OFS_CFG
    && cpu_wdata[2] |=> prot_reject)
    else $error("application enable write not refused");
  a_miss_hold: assert property (!cpu_wr && !dbg_wr && src_event == 16'h0000
    |=> $stable(missed))
    else $error("miss flags changed without cause");
endmodule

// ### verif/interrupt_miss_and_soft_trigger_tb.sv
module interrupt_miss_and_soft_trigger_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, ce, app_mode, cpu_wr, cpu_rd, dbg_wr, dbg_rd;
  logic [15:0] cpu_addr, cpu_wdata, dbg_addr, dbg_wdata, src_event, src_clear;
  logic [15:0] cpu_rdata, dbg_rdata, pending, missed;
  logic irq, software_source, prot_reject;
  int num_errors = 0;
  int compares = 0;
  ims_interrupt_unit DUT (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .app_mode(app_mode),
    .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata),
    .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata),
    .dbg_addr(dbg_addr),
    .dbg_wdata(dbg_wdata),
    .dbg_wr(dbg_wr),
    .dbg_rd(dbg_rd),
    .dbg_rdata(dbg_rdata),
    .src_event(src_event),
    .src_clear(src_clear),
    .irq(irq),
    .pending(pending),
    .missed(missed),
    .software_source(software_source),
    .prot_reject(prot_reject)
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // address and data go to both ports; only the chosen strobe qualifies them
  task automatic acc(input bit dbg, input bit w, input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    cpu_addr <= a;
    dbg_addr <= a;
    cpu_wdata <= d;
    dbg_wdata <= d;
    cpu_wr <= w & !dbg;
    dbg_wr <= w & dbg;
    cpu_rd <= !w & !dbg;
    dbg_rd <= !w & dbg;
    @(posedge core_clk);
    {cpu_wr, dbg_wr, cpu_rd, dbg_rd} <= 4'h0;
    #1;
    if (!w)
      chk(dbg ? dbg_rdata : cpu_rdata, d);
  endtask
  task automatic drv(input bit m, input logic [15:0] e, input logic [15:0] c);
    @(posedge core_clk);
    app_mode <= m;
    src_event <= e;
    src_clear <= c;
    @(posedge core_clk);
    src_event <= 16'h0000;
    src_clear <= 16'h0000;
    #1;
  endtask
  task automatic t_soft_trigger;
    acc(0, 0, ims_pkg::OFS_MISS, ims_pkg::RST_MISS);
    acc(0, 0, ims_pkg::OFS_SWTRIG, ims_pkg::RST_SWTRIG);
    acc(1, 0, 16'h4606, 16'h0000);
    acc(0, 1, ims_pkg::OFS_SWTRIG, 16'h1234);
    chk(16'(software_source), 16'h0001);
    chk(pending, 16'h0002);
    acc(0, 0, ims_pkg::OFS_SWTRIG, 16'h1234);
    acc(1, 1, ims_pkg::OFS_SWTRIG, 16'h0000);
    chk(16'(software_source), 16'h0001);
    // second trigger lands while the first is still pending, so it is counted as missed
    chk(missed, 16'h0002);
    acc(1, 1, ims_pkg::OFS_MISS, 16'h0002);
    chk(missed, 16'h0000);
  endtask
  task automatic t_miss_flags;
    drv(0, 16'h040c, 16'h0000);
    drv(1, 16'h040c, 16'h0000);
    chk(missed, 16'h040c);
    acc(0, 1, ims_pkg::OFS_MISS, 16'h040c);
    chk(missed, 16'h040c);
    chk(16'(prot_reject), 16'h0001);
    drv(0, 16'h0000, 16'h040c);
    chk(pending, 16'h0006);
    acc(0, 1, ims_pkg::OFS_MISS, 16'h0408);
    chk(missed, 16'h0004);
    drv(1, 16'h0000, 16'h0000);
    acc(1, 1, ims_pkg::OFS_MISS, 16'h0004);
    chk(missed, 16'h0000);
    acc(1, 0, ims_pkg::OFS_MISS, 16'h0000);
  endtask
  task automatic t_enable_irq;
    acc(0, 1, ims_pkg::OFS_CFG, 16'h0004);
    chk(16'(prot_reject), 16'h0001);
    acc(0, 1, ims_pkg::OFS_GEN, 16'h0001);
    acc(0, 0, ims_pkg::OFS_CFG, 16'h0000);
    chk(16'(irq), 16'h0000);
    acc(0, 1, ims_pkg::OFS_FLAG, 16'h0004);
    chk(pending, 16'h0006);
    drv(0, 16'h0000, 16'h0000);
    acc(0, 1, ims_pkg::OFS_CFG, 16'h0004);
    acc(0, 0, ims_pkg::OFS_CFG, 16'h0004);
    chk(16'(irq), 16'h0001);
    acc(0, 1, ims_pkg::OFS_FLAG, 16'h0006);
    acc(0, 0, ims_pkg::OFS_FLAG, 16'h0000);
    chk(16'(irq), 16'h0000);
    // the write-only clear register drops pending bits and reads back as zero
    acc(0, 1, ims_pkg::OFS_SWTRIG, 16'h0000);
    chk(pending, 16'h0002);
    acc(0, 1, ims_pkg::OFS_CLR, 16'h0002);
    chk(pending, 16'h0000);
    chk(missed, 16'h0000);
    acc(0, 0, ims_pkg::OFS_CLR, 16'h0000);
  endtask
  task automatic conclude;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    {rst_n, app_mode, cpu_wr, cpu_rd, dbg_wr, dbg_rd} = 6'h00;
    ce = 1'b1;
    {cpu_addr, cpu_wdata, dbg_addr, dbg_wdata, src_event, src_clear} = '0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    t_soft_trigger;
    t_miss_flags;
    t_enable_irq;
    conclude;
  end
  // a hang counts as a mismatch and still reaches the verdict
  initial
  begin
    repeat (2000) @(posedge core_clk);
    num_errors++;
    conclude;
  end
endmodule
bind ims_interrupt_unit ims_interrupt_unit_properties u_props (
  .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .app_mode(app_mode),
  .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
  .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_wr(dbg_wr), .dbg_rd(dbg_rd),
  .dbg_rdata(dbg_rdata), .src_event(src_event), .pending(pending), .missed(missed),
  .software_source(software_source), .prot_reject(prot_reject)
);
